// ===== gal_regs.svh
// Constants of the group address latch update slave: addresses, field positions, reset values.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef GAL_REGS_SVH
`define GAL_REGS_SVH

// ==========================================================
// Bus addressing and bit counting
`define GAL_GROUP_ADDR 7'h7E
`define GAL_BITS_PER_BYTE 4'h8
`define GAL_BIT_CNT_ZERO 4'h0
`define GAL_BIT_CNT_ONE 4'h1

// ==========================================================
// Byte positions inside a write transfer
`define GAL_BYTE_ADDR 2'h0
`define GAL_BYTE_CMD 2'h1
`define GAL_BYTE_LSB 2'h2
`define GAL_BYTE_MSB 2'h3
`define GAL_BYTE_STEP 2'h1

// ==========================================================
// Command byte fields and MSB data byte code field
`define GAL_CMD_DEFER_BIT 0
`define GAL_CMD_SHUTDOWN_BIT 1
`define GAL_CMD_BANDGAP_BIT 2
`define GAL_MSB_CODE_HI 1

// ==========================================================
// Reset values
`define GAL_CMD_RESET 8'h00
`define GAL_CODE_RESET 10'h000
`define GAL_BYTE_RESET 8'h00

`endif

// ===== gal_pkg.sv
// Types shared by the group address latch update slave.
// Assumes gal_regs.svh is on the include path.
`include "gal_regs.svh"

package gal_pkg;

    // ==========================================================
    // Latched converter settings
    typedef struct packed {
        logic bandgap;
        logic shutdown;
        logic [9:0] code;
    } gal_latch_type;

    // ==========================================================
    // Receiver states, one-hot
    typedef enum logic [3:0] {
        GAL_ST_IDLE = 4'h1,
        GAL_ST_RECV = 4'h2,
        GAL_ST_ACK = 4'h4,
        GAL_ST_SKIP = 4'h8
    } gal_state_type;

endpackage : gal_pkg

// ===== gal_sync.sv
// Two flip-flop synchroniser for pin inputs.
// Assumes inputs change asynchronously to sys_clk.
`timescale 1ns/1ns

module gal_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Asynchronous in, synchronous out
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_reg;

    // ==========================================================
    // First stage feeds only the second
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_reg <= '1;
            sync_out <= '1;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end

endmodule : gal_sync

// ===== gal_top.sv
// Two-wire slave receiver with own and group address, input registers and output latches.
// Assumes scl, sda and the address straps arrive asynchronously; sda is open drain, resolved outside.
`timescale 1ns/1ns
`include "gal_regs.svh"

module gal_top (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Bus pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Own slave address straps
    input wire logic [6:0] own_addr,
    // Latched outputs
    output gal_pkg::gal_latch_type out_latch,
    output logic deferred_update_select
);

    logic [8:0] sync_q;
    logic scl_s;
    logic sda_s;
    logic [6:0] addr_s;
    logic scl_d;
    logic sda_d;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    gal_pkg::gal_state_type state_reg;
    logic [3:0] bit_cnt_reg;
    logic [1:0] byte_idx_reg;
    logic [7:0] shift_reg;
    logic group_reg;
    logic update_or_clear_select_reg;
    logic [7:0] cmd_in_reg;
    logic [7:0] lsb_tmp_reg;
    logic [9:0] data_in_reg;
    logic pending_reg;
    logic byte_done;
    logic addr_hit;
    logic group_hit;
    logic ack_rise;
    logic do_clear;
    logic do_transfer;

    // ==========================================================
    // Pin synchronisers
    gal_sync #(
        .WIDTH(9)
    ) u_sync (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .async_in({own_addr, sda_in, scl_in}),
        .sync_out(sync_q)
    );

    assign scl_s = sync_q[0];
    assign sda_s = sync_q[1];
    assign addr_s = sync_q[8:2];

    // Delayed copies for edge finding
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_d <= scl_s;
            sda_d <= sda_s;
        end
    end

    // ==========================================================
    // Bus events
    assign scl_rise = scl_s & ~scl_d;
    assign scl_fall = ~scl_s & scl_d;
    assign start_seen = scl_s & scl_d & sda_d & ~sda_s;
    assign stop_seen = scl_s & scl_d & ~sda_d & sda_s;
    assign byte_done = (state_reg == gal_pkg::GAL_ST_RECV) & scl_fall & (bit_cnt_reg == `GAL_BITS_PER_BYTE);
    // Own address is write only; the slave never transmits
    assign addr_hit = (shift_reg[7:1] == addr_s) & ~shift_reg[0];
    assign group_hit = (shift_reg[7:1] == `GAL_GROUP_ADDR);
    assign ack_rise = (state_reg == gal_pkg::GAL_ST_ACK) & scl_rise & group_reg;
    assign deferred_update_select = cmd_in_reg[`GAL_CMD_DEFER_BIT];
    // Clear ignores the deferred select on purpose
    assign do_clear = ack_rise & ~update_or_clear_select_reg;
    assign do_transfer = (ack_rise & update_or_clear_select_reg & deferred_update_select)
        | (stop_seen & pending_reg & ~deferred_update_select);

    // ==========================================================
    // Receiver state machine
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= gal_pkg::GAL_ST_IDLE;
        end else if (stop_seen) begin
            state_reg <= gal_pkg::GAL_ST_IDLE;
        end else if (start_seen) begin
            state_reg <= gal_pkg::GAL_ST_RECV;
        end else begin
            case (state_reg)
                gal_pkg::GAL_ST_IDLE: begin
                    state_reg <= gal_pkg::GAL_ST_IDLE;
                end
                gal_pkg::GAL_ST_RECV: begin
                    if (byte_done) begin
                        if (byte_idx_reg != `GAL_BYTE_ADDR || addr_hit || group_hit) begin
                            state_reg <= gal_pkg::GAL_ST_ACK;
                        end else begin
                            state_reg <= gal_pkg::GAL_ST_SKIP;
                        end
                    end
                end
                gal_pkg::GAL_ST_ACK: begin
                    // Nothing follows a group command or the last data byte
                    if (scl_fall) begin
                        if (group_reg || byte_idx_reg == `GAL_BYTE_MSB) begin
                            state_reg <= gal_pkg::GAL_ST_SKIP;
                        end else begin
                            state_reg <= gal_pkg::GAL_ST_RECV;
                        end
                    end
                end
                gal_pkg::GAL_ST_SKIP: begin
                    state_reg <= gal_pkg::GAL_ST_SKIP;
                end
                default: begin
                    state_reg <= gal_pkg::GAL_ST_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // Bit and byte counters, shifter
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            bit_cnt_reg <= `GAL_BIT_CNT_ZERO;
            byte_idx_reg <= `GAL_BYTE_ADDR;
            shift_reg <= `GAL_BYTE_RESET;
        end else if (start_seen) begin
            bit_cnt_reg <= `GAL_BIT_CNT_ZERO;
            byte_idx_reg <= `GAL_BYTE_ADDR;
        end else if (state_reg == gal_pkg::GAL_ST_RECV && scl_rise) begin
            shift_reg <= {shift_reg[6:0], sda_s};
            bit_cnt_reg <= bit_cnt_reg + `GAL_BIT_CNT_ONE;
        end else if (state_reg == gal_pkg::GAL_ST_ACK && scl_fall) begin
            bit_cnt_reg <= `GAL_BIT_CNT_ZERO;
            byte_idx_reg <= byte_idx_reg + `GAL_BYTE_STEP;
        end
    end

    // Group flag from the address match, select from the read/write position
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            group_reg <= 1'b0;
            update_or_clear_select_reg <= 1'b0;
        end else if (start_seen) begin
            group_reg <= 1'b0;
        end else if (byte_done && byte_idx_reg == `GAL_BYTE_ADDR) begin
            group_reg <= group_hit;
            update_or_clear_select_reg <= shift_reg[0];
        end
    end

    // ==========================================================
    // Acknowledge drive, held from falling edge to falling edge
    assign sda_out = 1'b0;
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            sda_oe <= 1'b0;
        end else if (start_seen || stop_seen) begin
            sda_oe <= 1'b0;
        end else if (byte_done && (byte_idx_reg != `GAL_BYTE_ADDR || addr_hit || group_hit)) begin
            sda_oe <= 1'b1;
        end else if (state_reg == gal_pkg::GAL_ST_ACK && scl_fall) begin
            sda_oe <= 1'b0;
        end
    end

    // ==========================================================
    // Input registers; data bytes count only as a complete pair
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            cmd_in_reg <= `GAL_CMD_RESET;
            lsb_tmp_reg <= `GAL_BYTE_RESET;
            data_in_reg <= `GAL_CODE_RESET;
            pending_reg <= 1'b0;
        end else if (do_clear) begin
            cmd_in_reg <= `GAL_CMD_RESET;
            lsb_tmp_reg <= `GAL_BYTE_RESET;
            data_in_reg <= `GAL_CODE_RESET;
            pending_reg <= 1'b0;
        end else if (stop_seen) begin
            pending_reg <= 1'b0;
        end else if (byte_done && byte_idx_reg == `GAL_BYTE_CMD) begin
            cmd_in_reg <= shift_reg;
            pending_reg <= 1'b1;
        end else if (byte_done && byte_idx_reg == `GAL_BYTE_LSB) begin
            lsb_tmp_reg <= shift_reg;
        end else if (byte_done && byte_idx_reg == `GAL_BYTE_MSB) begin
            data_in_reg <= {shift_reg[`GAL_MSB_CODE_HI:0], lsb_tmp_reg};
        end
    end

    // ==========================================================
    // Output latches
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            out_latch <= '0;
        end else if (do_clear) begin
            out_latch <= '0;
        end else if (do_transfer) begin
            out_latch.code <= data_in_reg;
            out_latch.shutdown <= cmd_in_reg[`GAL_CMD_SHUTDOWN_BIT];
            out_latch.bandgap <= cmd_in_reg[`GAL_CMD_BANDGAP_BIT];
        end
    end

endmodule : gal_top

// ===== gal_top_assertions.sv
// Checker for the group address slave, watching only the ports of gal_top.
// Assumes a bind onto gal_top; sda_oe high means the slave pulls sda low.
`timescale 1ns/1ns

// ==========
// Checker
module gal_top_assertions (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Bus pins
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    // Latched outputs
    input wire gal_pkg::gal_latch_type out_latch,
    input wire logic deferred_update_select
);
    // One domain only, so clock and reset are given once
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    // Acknowledge framing; bounds allow for the three-flop input delay
    a_ack_drives_low: assert property (sda_oe |-> !sda_out)
        else $error("ack enable without low drive");
    a_ack_rise_low: assert property ($rose(sda_oe) |-> !scl_in)
        else $error("ack began while scl high");
    a_ack_fall_low: assert property ($fell(sda_oe) |-> !scl_in)
        else $error("ack released while scl high");
    a_ack_whole_pulse: assert property ($rose(sda_oe) |-> sda_oe[*4] ##[1:8] !sda_oe)
        else $error("ack length out of range");

    // Latch moves only at a group ack or a stop
    a_latch_at_event: assert property ($changed(out_latch) |-> sda_oe || (scl_in && sda_in))
        else $error("latch changed outside ack or stop");
    a_group_needs_defer: assert property ($changed(out_latch) && sda_oe && out_latch != '0
        |-> $past(deferred_update_select))
        else $error("group update without deferred select");
    a_stop_needs_nodefer: assert property ($changed(out_latch) && !sda_oe
        |-> !$past(deferred_update_select))
        else $error("stop update while deferred");
    a_defer_at_ack: assert property ($changed(deferred_update_select) |-> sda_oe || $past(sda_oe))
        else $error("deferred select changed outside ack");
endmodule : gal_top_assertions

bind gal_top gal_top_assertions u_gal_top_assertions (.sys_clk, .reset_n, .scl_in, .sda_in,
    .sda_out, .sda_oe, .out_latch, .deferred_update_select);

// ===== gal_master_model.sv
// Two-wire bus master model: start, stop and byte writes with ack sampling.
// Assumes the bench resolves sda with a pull-up and feeds it back here.
`timescale 1ns/1ns

// ==========
// Master
module gal_master_model (
    // Bus clock, still between frames
    output logic scl,
    // Open drain data, high pulls low
    output logic sda_low,
    input wire logic sda
);
    // Idle bus, both lines released
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    // Start or repeated start; long first wait lets a slave ack end first
    task automatic start();
        sda_low = 1'b0;
        #200 scl = 1'b1;
        #80 sda_low = 1'b1;
        #80 scl = 1'b0;
        #40;
    endtask : start

    // Stop: sda rises while scl high
    task automatic stop();
        sda_low = 1'b1;
        #160 scl = 1'b1;
        #120 sda_low = 1'b0;
        #80;
    endtask : stop

    // One 320 ns bit; data moves 40 ns after scl falls, never with it
    task automatic put_bit(input logic b, output logic r);
        sda_low = !b;
        #160 scl = 1'b1;
        #60 r = sda;
        #60 scl = 1'b0;
        #40;
    endtask : put_bit

    // Byte then ack slot, with sda released for the slave
    task automatic put_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            put_bit(d[i], r);
        end
        put_bit(1'b1, r);
        ack = !r;
    endtask : put_byte
endmodule : gal_master_model

// ===== tb_top.sv
// Self-checking bench for gal_top driven by a bus master model.
// Assumes gal_pkg and gal_regs.svh are compiled first.
`timescale 1ns/1ns
`include "gal_regs.svh"

// ==========
// Bench
module tb_top;
    localparam logic [6:0] OWN_ADDR = 7'h15;
    logic sys_clk, reset_n, scl, sda_low, sda_out, sda_oe, deferred_update_select;
    logic [6:0] own_addr;
    gal_pkg::gal_latch_type out_latch;
    wire logic sda;
    int num_errors, checked;

    // Pull-up line, low if anyone pulls
    assign sda = !(sda_low || (sda_oe && !sda_out));

    gal_top u_gal_top (.sys_clk(sys_clk), .reset_n(reset_n), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .own_addr(own_addr), .out_latch(out_latch),
        .deferred_update_select(deferred_update_select));
    gal_master_model u_gal_master_model (.scl(scl), .sda_low(sda_low), .sda(sda));

    // 25 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = !sys_clk;
    end

    // Compare and count
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // Stop then let it pass the input synchroniser
    task automatic end_frame();
        u_gal_master_model.stop();
        repeat (6) @(posedge sys_clk);
        // Next frame starts just after an edge, never on it
        #1;
    endtask : end_frame

    // Address, command and data pair, every byte acked; no stop
    task automatic write_word(input logic [7:0] c, input logic [7:0] l, input logic [7:0] m);
        logic a;
        logic [7:0] b[4];
        b = '{{OWN_ADDR, 1'b0}, c, l, m};
        u_gal_master_model.start();
        foreach (b[i]) begin
            u_gal_master_model.put_byte(b[i], a);
            chk({11'h0, a}, 12'h1);
        end
    endtask : write_word

    // Quick command to the shared address, select in the direction slot
    task automatic group_cmd(input logic s);
        logic a;
        u_gal_master_model.start();
        u_gal_master_model.put_byte({`GAL_GROUP_ADDR, s}, a);
        chk({11'h0, a}, 12'h1);
    endtask : group_cmd

    // Normal mode: stop loads {bandgap, shutdown, code}
    task automatic t_stop_update();
        write_word(8'h06, 8'hA5, 8'h03);
        end_frame();
        chk(out_latch, 12'hFA5);
        chk({11'h0, deferred_update_select}, 12'h0);
    endtask : t_stop_update

    // Deferred: stop holds, group select 1 loads
    task automatic t_group_update();
        write_word(8'h01, 8'h3C, 8'h02);
        end_frame();
        chk(out_latch, 12'hFA5);
        chk({11'h0, deferred_update_select}, 12'h1);
        group_cmd(1'b1);
        chk(out_latch, 12'h23C);
        end_frame();
    endtask : t_group_update

    // Deferred cleared by new command: group select 1 ignored, stop loads
    task automatic t_group_ignored();
        write_word(8'h00, 8'h11, 8'h01);
        group_cmd(1'b1);
        chk(out_latch, 12'h23C);
        end_frame();
        chk(out_latch, 12'h111);
    endtask : t_group_ignored

    // Clear with deferred set empties latches and command
    task automatic t_group_clear();
        write_word(8'h07, 8'h5A, 8'h00);
        end_frame();
        chk(out_latch, 12'h111);
        group_cmd(1'b0);
        chk(out_latch, 12'h000);
        chk({11'h0, deferred_update_select}, 12'h0);
        end_frame();
        chk(out_latch, 12'h000);
    endtask : t_group_clear

    // Verdict and end of run
    task automatic complete_run();
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : complete_run

    // Main sequence; inputs move 1 ns after the edge
    initial begin
        reset_n = 1'b0;
        own_addr = OWN_ADDR;
        num_errors = 0;
        checked = 0;
        repeat (3) @(posedge sys_clk);
        #1 reset_n = 1'b1;
        repeat (4) @(posedge sys_clk);
        // Model steps are whole multiples of the 20 ns half period, so this offset keeps pins off the edge
        #1;
        t_stop_update();
        t_group_update();
        t_group_ignored();
        t_group_clear();
        complete_run();
    end

    // Watchdog, several times the expected run
    initial begin
        #400000;
        num_errors++;
        complete_run();
    end
endmodule : tb_top
